/* File: logic/mif_edge_sync.sv */
`timescale 1ns/1ps
module mif_edge_sync (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Raw and conditioned
  input wire logic din,
  output logic level,
  output logic rise,
  output logic fall
);
  logic s1;
  logic s2;
  // First stage feeds only the second
  always_ff @(posedge clock) begin
    if (!rstn) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      level <= 1'b0;
    end else begin
      s1 <= din;
      s2 <= s1;
      level <= s2;
    end
  end
  assign rise = s2 & ~level;
  assign fall = ~s2 & level;
endmodule // mif_edge_sync

/* File: logic/mif_fault_log.sv */
`timescale 1ns/1ps
`include "mif_map.svh"
module mif_fault_log (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Events and control
  input wire logic [31:0] err_events,
  input wire logic amp_enabled,
  input wire logic clear_req,
  input wire logic coldstart_protect,
  // Status
  output logic [31:0] err_pending,
  output mif_pkg::mif_code_t err_code
);
  import mif_pkg::*;
  logic [31:0] gated;
  logic [31:0] clr_mask;
  mif_code_t next_code;
  assign gated = err_events & (amp_enabled ? 32'hFFFF_FFFF : ~`MIF_MAINS_MASK);
  // Clearable set, plus coldstart faults unless protected
  assign clr_mask = `MIF_CLEARABLE_MASK
    | (coldstart_protect ? 32'h0000_0000 : `MIF_COLDSTART_MASK);
  always_ff @(posedge clock) begin
    if (!rstn) begin
      err_pending <= 32'h0000_0000;
    end else if (clear_req) begin
      // New events win over the clear
      err_pending <= (err_pending & ~clr_mask) | gated;
    end else begin
      err_pending <= err_pending | gated;
    end
  end
  // Lowest number shown first
  always_comb begin
    next_code = 6'h00;
    for (int i = `MIF_NUM_ERR - 1; i >= 0; i--) begin
      if (err_pending[i]) begin
        next_code = 6'(i + 1);
      end
    end
  end
  always_ff @(posedge clock) begin
    if (!rstn) begin
      err_code <= 6'h00;
    end else begin
      err_code <= next_code;
    end
  end
endmodule // mif_fault_log

/* File: logic/mif_map.svh */
// Contract
// - Task start rise launches, fall cancels; code pauses the task so resume continues it
// - Next-task output toggles per sequence task
// - Next-task output low at first task
// - Target reached high inside window
// - Following error output active low
// - Position register outputs high when satisfied
// - Jog edges start/stop, sign gives direction
// - Resume input continues interrupted task
// - Follow-on task starts only after target
// - Error clear drops following/monitor warnings
// - Card error on supply/overload/short
// - Report card auxiliary supply present
// - Error opens ready, disables stage, brakes
// - Active error reported as code 1-32
// - Mains errors suppressed until enabled
// - Clearable errors cleared without reset
// - Reset with only clearable errors clears
// - Unsupported identifier sets read error
// - Limit consequence 0 warning, 1 fault
// - Protection keeps coldstart faults on clear
// - Inversion flips loop input and output
`ifndef MIF_MAP_SVH
`define MIF_MAP_SVH
`define MIF_NUM_ERR 32
`define MIF_NUM_POSREG 5
`define MIF_POS_W 32
// Bit i stands for error code i+1
`define MIF_CLEARABLE_MASK 32'h0004_9093
`define MIF_MAINS_MASK 32'h0004_8000
`define MIF_COLDSTART_MASK 32'h8000_0600
`define MIF_LIMIT_ERR_BIT 25
`define MIF_IDN_MAX 16'h0FFF
`endif

/* File: logic/mif_motion_io.sv */
`timescale 1ns/1ps
`include "mif_map.svh"
module mif_motion_io (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Controller inputs
  input wire logic task_start_input,
  input wire logic [7:0] task_number_inputs,
  input wire logic jog_input,
  input wire logic task_resume_input,
  input wire logic follow_on_task_input,
  input wire logic following_error_clear_input,
  input wire logic reset_input,
  // Configuration
  input wire logic signed [31:0] jog_speed,
  input wire logic [31:0] target_reached_output_window,
  input wire logic [31:0] ferr_window,
  input wire mif_pkg::mif_pos_t posreg_preset [5],
  input wire logic [4:0] posreg_above,
  input wire logic [7:0] follow_on_number,
  input wire logic follow_on_enable,
  input wire logic sequence_auto,
  input wire logic limit_switch_consequence,
  input wire logic coldstart_clear_protection,
  input wire logic position_invert,
  input wire logic clear_fault_command,
  input wire logic amp_enabled,
  // Position loop
  input wire mif_pkg::mif_pos_t target_pos,
  input wire mif_pkg::mif_pos_t actual_pos,
  output mif_pkg::mif_pos_t loop_cmd_diff,
  // Monitors
  input wire logic [31:0] err_events,
  input wire logic limit_hit,
  input wire logic monitor_timeout,
  input wire logic card_supply_missing,
  input wire logic card_overload,
  input wire logic card_short,
  input wire logic card_supply_ok,
  // Identifier read
  input wire logic idn_read,
  input wire logic [15:0] idn_number,
  input wire logic [7:0] list_element_select,
  input wire logic idn_is_list,
  // Motion outputs
  output logic task_active,
  output logic [7:0] task_number,
  output logic jog_active,
  output logic jog_reverse,
  output logic signed [31:0] jog_speed_mag,
  output logic next_task_toggle_output,
  output logic target_reached_output,
  output logic following_error_output,
  output logic [4:0] position_register_outputs,
  // Status outputs
  output logic card_error_output,
  output logic card_supply_present,
  output logic ready_contact,
  output logic stage_enable,
  output logic brake_engage,
  output mif_pkg::mif_code_t err_code,
  output logic ferr_warning,
  output logic monitor_warning,
  output logic limit_warning,
  output logic identifier_read_error_flag,
  output logic [7:0] list_element_latched
);
  import mif_pkg::*;

  logic st_rise;
  logic st_fall;
  logic jg_rise;
  logic jg_fall;
  logic rs_rise;
  logic fo_rise;
  logic fc_rise;
  logic rst_rise;
  logic reach_rise;
  logic advance;
  mif_motion_t motion;
  logic [31:0] err_pending;
  logic [31:0] all_events;
  logic [31:0] pos_err;
  logic in_window;
  logic clear_req;
  logic only_clearable;

  function automatic logic [31:0] abs_diff(input mif_pos_t a, input mif_pos_t b);
    logic signed [31:0] d;
    d = $signed(a) - $signed(b);
    return d[31] ? 32'(-d) : 32'(d);
  endfunction

  function automatic mif_pos_t pos_delta(input mif_pos_t a, input mif_pos_t b);
    return 32'($signed(a) - $signed(b));
  endfunction

  // Each control pin: two-flop sync, then edge detect
  mif_edge_sync u_st (
    .clock(clock),
    .rstn(rstn),
    .din(task_start_input),
    .level(),
    .rise(st_rise),
    .fall(st_fall)
  );
  mif_edge_sync u_jg (
    .clock(clock),
    .rstn(rstn),
    .din(jog_input),
    .level(),
    .rise(jg_rise),
    .fall(jg_fall)
  );
  mif_edge_sync u_rs (
    .clock(clock),
    .rstn(rstn),
    .din(task_resume_input),
    .level(),
    .rise(rs_rise),
    .fall()
  );
  mif_edge_sync u_fo (
    .clock(clock),
    .rstn(rstn),
    .din(follow_on_task_input),
    .level(),
    .rise(fo_rise),
    .fall()
  );
  mif_edge_sync u_fc (
    .clock(clock),
    .rstn(rstn),
    .din(following_error_clear_input),
    .level(),
    .rise(fc_rise),
    .fall()
  );
  mif_edge_sync u_rt (
    .clock(clock),
    .rstn(rstn),
    .din(reset_input),
    .level(),
    .rise(rst_rise),
    .fall()
  );

  // Position deviation magnitude, not affected by inverted polarity
  assign pos_err = abs_diff(target_pos, actual_pos);
  assign in_window = pos_err <= target_reached_output_window;
  // Arrival edge, so a held arrival starts only one follow-on
  assign reach_rise = in_window & ~target_reached_output;
  assign advance = motion == mif_task && ~|err_pending && follow_on_enable
    && ((fo_rise && target_reached_output) || (sequence_auto && reach_rise));

  always_ff @(posedge clock) begin
    if (!rstn) begin
      loop_cmd_diff <= 32'h0000_0000;
    end else if (position_invert) begin
      loop_cmd_diff <= pos_delta(actual_pos, target_pos);
    end else begin
      loop_cmd_diff <= pos_delta(target_pos, actual_pos);
    end
  end

  // Motion state; faults halt everything
  always_ff @(posedge clock) begin
    if (!rstn) begin
      motion <= mif_idle;
      task_number <= 8'h00;
    end else if (|err_pending) begin
      motion <= mif_idle;
    end else begin
      case (motion)
        mif_idle: begin
          if (st_rise) begin
            motion <= mif_task;
            task_number <= task_number_inputs;
          end else if (jg_rise) begin
            motion <= mif_jog;
          end else if (rs_rise && task_number != 8'h00) begin
            motion <= mif_task;
          end
        end
        mif_task: begin
          if (st_fall) begin
            motion <= mif_paused;
          end else if (advance) begin
            task_number <= follow_on_number;
          end
        end
        mif_jog: begin
          if (jg_fall) begin
            motion <= mif_idle;
          end
        end
        mif_paused: begin
          if (rs_rise) begin
            motion <= mif_task;
          end else if (st_rise) begin
            motion <= mif_task;
            task_number <= task_number_inputs;
          end else if (jg_rise) begin
            motion <= mif_jog;
          end
        end
        default: motion <= mif_idle;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      task_active <= 1'b0;
      jog_active <= 1'b0;
    end else begin
      task_active <= motion == mif_task;
      jog_active <= motion == mif_jog;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      jog_reverse <= 1'b0;
      jog_speed_mag <= 32'sh0000_0000;
    end else if (jg_rise) begin
      jog_reverse <= jog_speed[31];
      jog_speed_mag <= jog_speed[31] ? -jog_speed : jog_speed;
    end
  end

  // Toggle per task start in a sequence
  always_ff @(posedge clock) begin
    if (!rstn) begin
      next_task_toggle_output <= 1'b0;
    end else if (motion != mif_task && (st_rise || rs_rise)) begin
      next_task_toggle_output <= 1'b0;
    end else if (advance) begin
      next_task_toggle_output <= ~next_task_toggle_output;
    end
  end

  // Line break is not sensed
  always_ff @(posedge clock) begin
    if (!rstn) begin
      target_reached_output <= 1'b0;
      following_error_output <= 1'b1;
    end else begin
      target_reached_output <= in_window;
      following_error_output <= ~(pos_err > ferr_window);
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      position_register_outputs <= 5'h00;
    end else begin
      for (int i = 0; i < `MIF_NUM_POSREG; i++) begin
        position_register_outputs[i] <= posreg_above[i]
          ? ($signed(actual_pos) >= $signed(posreg_preset[i]))
          : ($signed(actual_pos) < $signed(posreg_preset[i]));
      end
    end
  end

  // Warnings: set wins over clear
  always_ff @(posedge clock) begin
    if (!rstn) begin
      ferr_warning <= 1'b0;
      monitor_warning <= 1'b0;
    end else begin
      ferr_warning <= (pos_err > ferr_window) | (ferr_warning & ~fc_rise);
      monitor_warning <= monitor_timeout | (monitor_warning & ~fc_rise);
    end
  end

  // Consequence 0 only warns; 1 feeds the fault log instead
  always_ff @(posedge clock) begin
    if (!rstn) begin
      limit_warning <= 1'b0;
    end else begin
      limit_warning <= (limit_hit & ~limit_switch_consequence)
        | (limit_warning & ~clear_req);
    end
  end

  always_comb begin
    all_events = err_events;
    all_events[`MIF_LIMIT_ERR_BIT] = err_events[`MIF_LIMIT_ERR_BIT]
      | (limit_hit & limit_switch_consequence);
  end

  // Reset button acts as clear when only clearable faults remain
  assign only_clearable = (err_pending & ~`MIF_CLEARABLE_MASK) == 32'h0000_0000;
  assign clear_req = clear_fault_command | (rst_rise & only_clearable);

  mif_fault_log u_log (
    .clock(clock),
    .rstn(rstn),
    .err_events(all_events),
    .amp_enabled(amp_enabled),
    .clear_req(clear_req),
    .coldstart_protect(coldstart_clear_protection),
    .err_pending(err_pending),
    .err_code(err_code)
  );

  // Any pending error drops torque and holds the brake
  always_ff @(posedge clock) begin
    if (!rstn) begin
      ready_contact <= 1'b0;
      stage_enable <= 1'b0;
      brake_engage <= 1'b1;
    end else begin
      ready_contact <= ~|err_pending;
      stage_enable <= ~|err_pending & amp_enabled;
      brake_engage <= |err_pending | ~amp_enabled;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      card_error_output <= 1'b0;
      card_supply_present <= 1'b0;
    end else begin
      card_error_output <= card_supply_missing | card_overload | card_short;
      card_supply_present <= card_supply_ok;
    end
  end

  // Element chosen before the read is used
  always_ff @(posedge clock) begin
    if (!rstn) begin
      identifier_read_error_flag <= 1'b0;
      list_element_latched <= 8'h00;
    end else if (idn_read) begin
      list_element_latched <= list_element_select;
      identifier_read_error_flag <= (idn_number > `MIF_IDN_MAX) | ~idn_is_list;
    end
  end
endmodule // mif_motion_io

/* File: logic/mif_pkg.sv */
package mif_pkg;
  typedef enum logic [1:0] {mif_idle, mif_task, mif_jog, mif_paused} mif_motion_t;
  typedef logic [31:0] mif_pos_t;
  typedef logic [5:0] mif_code_t;
endpackage

/* File: tb/mif_ctrl_model.sv */
`timescale 1ns/1ps
module mif_ctrl_model (
  input wire logic clock,
  input wire logic [5:0] req,
  output logic [5:0] pins
);
  // Controller pins move only just after an edge, never mid-cycle
  initial pins = 6'h00;
  always @(posedge clock) pins <= #1 req;
endmodule // mif_ctrl_model

/* File: tb/mif_motion_io_sva.sv */
`timescale 1ns/1ps
`include "mif_map.svh"
module mif_motion_io_sva (
  // Clock, reset and controls
  input wire logic clock, rstn, position_invert, idn_read, idn_is_list,
  input wire logic card_supply_missing, card_overload, card_short, card_supply_ok,
  // Observed outputs and the settings and positions they depend on
  input wire logic card_error_output, card_supply_present, identifier_read_error_flag,
  input wire logic ready_contact, stage_enable, brake_engage, task_active,
  input wire logic next_task_toggle_output, target_reached_output, following_error_output,
  input wire logic [4:0] posreg_above, position_register_outputs,
  input wire logic [15:0] idn_number,
  input wire logic [31:0] target_reached_output_window, ferr_window,
  input wire mif_pkg::mif_pos_t target_pos, actual_pos, loop_cmd_diff, posreg_preset [5],
  input wire mif_pkg::mif_code_t err_code
);
  import mif_pkg::*;
  logic [2:0] up;
  // Holds off the window checks until reset values have flushed
  always_ff @(posedge clock) up <= !rstn ? 3'h0 : (up == 3'h7 ? up : up + 3'h1);
  wire signed [31:0] dv = target_pos - actual_pos;
  wire [31:0] adv = dv[31] ? -dv : dv;
  wire card_bad = card_supply_missing | card_overload | card_short;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  sequence s_pos;
    up == 3'h7 && $stable(target_pos) && $stable(actual_pos) && $stable(position_invert) &&
      $stable(target_reached_output_window) && $stable(ferr_window) && $stable(posreg_preset[0]) &&
      $stable(posreg_above[0]);
  endsequence
  sequence s_still; s_pos [*5]; endsequence
  sequence s_card;
    (up == 3'h7 && $stable({card_bad, card_supply_ok})) [*5];
  endsequence
  property p_target_reached_output; s_still ##0 (adv < target_reached_output_window) |-> target_reached_output; endproperty
  property p_ferr; s_still ##0 (adv > ferr_window) |-> !following_error_output; endproperty
  property p_preg;
    s_still |-> position_register_outputs[0] == (posreg_above[0] ?
      $signed(actual_pos) >= $signed(posreg_preset[0]) :
      $signed(actual_pos) < $signed(posreg_preset[0]));
  endproperty
  property p_inv;
    s_still |-> loop_cmd_diff == (position_invert ? actual_pos - target_pos
      : target_pos - actual_pos);
  endproperty
  property p_card;
    s_card |-> card_error_output == card_bad && card_supply_present == card_supply_ok;
  endproperty
  property p_idn;
    idn_read && (idn_number > `MIF_IDN_MAX || !idn_is_list) |=> identifier_read_error_flag;
  endproperty
  property p_err;
    err_code != 6'h00 |-> !ready_contact && !stage_enable && brake_engage;
  endproperty
  property p_code; err_code <= 6'h20; endproperty
  property p_first; $rose(task_active) |-> !next_task_toggle_output; endproperty
  a_target_reached_output: assert property (p_target_reached_output) else $error("in-position low in window");
  a_ferr: assert property (p_ferr) else $error("following error not low");
  a_preg: assert property (p_preg) else $error("position register wrong");
  a_inv: assert property (p_inv) else $error("loop difference wrong");
  a_card: assert property (p_card) else $error("card status wrong");
  a_idn: assert property (p_idn) else $error("read error flag not set");
  a_err: assert property (p_err) else $error("stage live during error");
  a_code: assert property (p_code) else $error("error code out of range");
  a_first: assert property (p_first) else $error("toggle not low at start");
endmodule // mif_motion_io_sva
bind mif_motion_io mif_motion_io_sva u_sva (.*);

/* File: tb/testbench.sv */
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin n_mismatch++; \
  $display("Error at %0t: got %h expected %h", $time, a, e); end end
module testbench;
  import mif_pkg::*;
  logic clock = 0, rstn = 0, amp_enabled = 1, idn_read = 0, idn_is_list = 1;
  logic follow_on_enable = 0, sequence_auto = 0, limit_switch_consequence = 0;
  logic coldstart_clear_protection = 0, position_invert = 0, clear_fault_command = 0;
  logic limit_hit = 0, monitor_timeout = 0, card_supply_missing = 0, card_overload = 0;
  logic card_short = 0, card_supply_ok = 0;
  logic [4:0] posreg_above = 5'h15;
  logic [5:0] req = 6'h00;
  logic [7:0] task_number_inputs = 8'h00, follow_on_number = 8'h00, list_element_select = 8'h00;
  logic [15:0] idn_number = 16'h0000;
  logic [31:0] target_reached_output_window = 32'hA, ferr_window = 32'h1E, err_events = 32'h0;
  logic signed [31:0] jog_speed = 32'h0;
  mif_pos_t target_pos = 32'h0, actual_pos = 32'h0, posreg_preset [5] = '{default: 32'h0};
  wire task_start_input, jog_input, task_resume_input, follow_on_task_input;
  wire following_error_clear_input, reset_input;
  logic task_active, jog_active, jog_reverse, next_task_toggle_output, target_reached_output;
  logic following_error_output, card_error_output, card_supply_present, ready_contact;
  logic stage_enable, brake_engage, ferr_warning, monitor_warning, limit_warning;
  logic identifier_read_error_flag;
  logic [4:0] position_register_outputs;
  logic [7:0] task_number, list_element_latched;
  logic signed [31:0] jog_speed_mag;
  mif_code_t err_code;
  mif_pos_t loop_cmd_diff;
  int n_mismatch = 0, total_checks = 0, cycles = 0, id_q[$];
  logic [31:0] ev_q[$];
  int dlt[4] = '{0, 5, -20, 40};
  mif_ctrl_model u_ctrl (.clock(clock), .req(req), .pins({task_start_input, jog_input,
    task_resume_input, follow_on_task_input, following_error_clear_input, reset_input}));
  mif_motion_io u_dut (.*);
  initial forever #10 clock = ~clock;
  function automatic logic [31:0] pick(input int s);
    case (s)
      0: return task_active;
      1: return task_number;
      2: return next_task_toggle_output;
      3: return target_reached_output;
      4: return following_error_output;
      5: return position_register_outputs;
      6: return {ready_contact, stage_enable, brake_engage};
      7: return err_code;
      8: return {card_error_output, card_supply_present};
      9: return limit_warning;
      10: return identifier_read_error_flag;
      11: return loop_cmd_diff;
      12: return jog_active;
      13: return jog_reverse;
      14: return monitor_warning;
      15: return list_element_latched;
      16: return ferr_warning;
      default: return jog_speed_mag;
    endcase
  endfunction
  task automatic note(input int s, input logic [31:0] e);
    id_q.push_back(s);
    ev_q.push_back(e);
  endtask
  // Results are compared away from the launching edge
  always @(negedge clock) begin
    logic [31:0] e, a;
    while (id_q.size() > 0) begin
      a = pick(id_q.pop_front());
      e = ev_q.pop_front();
      `CHK(a, e)
    end
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic pulse_err(input logic [31:0] v);
    err_events = v;
    cyc(1);
    err_events = 32'h0;
    cyc(4);
  endtask
  task automatic clr();
    clear_fault_command = 1;
    cyc(1);
    clear_fault_command = 0;
    cyc(4);
  endtask
  task automatic do_reset(input string t);
    $display("Test %s done", t);
    rstn = 0;
    cyc(3);
    rstn = 1;
    cyc(2);
  endtask
  task automatic final_report();
    $display("Checks %0d, mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Bounded run: roughly six and a half times the expected length
  always @(posedge clock) begin
    cycles++;
    if (cycles > 2000) begin
      n_mismatch++;
      final_report();
    end
  end
  initial begin
    void'($urandom(789));
    cyc(3);
    rstn = 1;
    cyc(2);
    jog_speed = $urandom;
    req[4] = 1;
    cyc(8);
    note(12, 1);
    note(13, jog_speed[31]);
    note(17, jog_speed < 0 ? -jog_speed : jog_speed);
    req[4] = 0;
    cyc(8);
    note(12, 0);
    task_number_inputs = 8'($urandom_range(255, 1));
    req[5] = 1;
    cyc(8);
    note(0, 1);
    note(1, task_number_inputs);
    note(2, 0);
    req[5] = 0;
    cyc(8);
    note(0, 0);
    req[3] = 1;
    cyc(8);
    note(0, 1);
    req[3] = 0;
    foreach (dlt[i]) begin
      target_pos = $urandom_range(32'h100000);
      actual_pos = target_pos + dlt[i];
      foreach (posreg_preset[k]) posreg_preset[k] = target_pos;
      position_invert = $urandom_range(1);
      cyc(8);
      note(3, dlt[i] < 10 && dlt[i] > -10);
      note(4, dlt[i] <= 30 && dlt[i] >= -30);
      note(5, posreg_above ^ {5{dlt[i] < 0}});
      note(11, position_invert ? dlt[i] : -dlt[i]);
    end
    follow_on_enable = 1;
    follow_on_number = 8'($urandom);
    req[2] = 1;
    cyc(8);
    note(1, task_number_inputs);
    note(2, 0);
    req[2] = 0;
    actual_pos = target_pos;
    cyc(8);
    req[2] = 1;
    cyc(8);
    note(1, follow_on_number);
    note(2, 1);
    req[2] = 0;
    sequence_auto = 1;
    actual_pos = target_pos + 40;
    cyc(4);
    actual_pos = target_pos;
    cyc(4);
    note(2, 0);
    {sequence_auto, follow_on_enable} = 2'h0;
    for (int c = 0; c < 16; c++) begin
      {card_supply_missing, card_overload, card_short, card_supply_ok} = 4'(c);
      cyc(6);
      note(8, {|c[3:1], c[0]});
    end
    list_element_select = 8'($urandom);
    idn_number = 16'h1000;
    idn_read = 1;
    cyc(1);
    idn_read = 0;
    cyc(2);
    note(10, 1);
    note(15, list_element_select);
    idn_number = 16'h0100;
    idn_read = 1;
    cyc(1);
    idn_read = 0;
    cyc(2);
    note(10, 0);
    monitor_timeout = 1;
    cyc(6);
    note(14, 1);
    note(16, 1);
    monitor_timeout = 0;
    req[1] = 1;
    cyc(8);
    req[1] = 0;
    note(14, 0);
    note(16, 0);
    do_reset("motion");
    pulse_err(32'h1);
    note(7, 1);
    note(6, 3'h1);
    clr();
    note(7, 0);
    note(6, 3'h6);
    pulse_err(32'h1);
    req[0] = 1;
    cyc(8);
    req[0] = 0;
    note(7, 0);
    coldstart_clear_protection = 1;
    pulse_err(32'h200);
    clr();
    note(7, 6'hA);
    coldstart_clear_protection = 0;
    clr();
    note(7, 0);
    do_reset("clear");
    amp_enabled = 0;
    err_events = 32'h8000;
    cyc(5);
    note(7, 0);
    amp_enabled = 1;
    cyc(5);
    note(7, 6'h10);
    err_events = 32'h0;
    do_reset("mains");
    limit_hit = 1;
    cyc(8);
    note(9, 1);
    note(7, 0);
    limit_switch_consequence = 1;
    cyc(8);
    note(7, 6'h1A);
    cyc(2);
    $display("Test limit done");
    final_report();
  end
endmodule // testbench
